//--- rtl/slcd_drv.sv
/*
 * Four-way multiplexed segment panel driver with its control registers
 * and display memory on the CPU byte bus.
 * Assumes all inputs synchronous to i_core_clk; level codes on the
 * outputs steer an external analog switch bank.
 */
module slcd_drv #(
    parameter bit EMULATION  = 1'b0,
    parameter int PRESCALE_W = slcd_pkg::PRESCALE_LOG2
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    output logic             o_rvalid,
    output logic      [7:0]  o_common_outputs,
    output logic      [39:0] o_segment_outputs,
    output logic      [19:0] o_segment_pin_mask,
    input  wire logic [19:0] i_port_in,
    input  wire logic [19:0] i_port_out_en,
    output logic      [19:0] o_port_read,
    output logic      [19:0] o_port_out_en,
    output logic             o_drive_supply_select
);
    localparam int NSEG = slcd_pkg::DMEM_WORDS;
    localparam int PW   = PRESCALE_W;

    generate
        if (PW < 4 || PW > 24) begin : g_bad
            $error("slcd_drv: PRESCALE_W out of range");
        end
    endgenerate

    typedef struct packed {
        logic [7:0]            mode;
        logic [7:0]            pinctl;
        logic                  gate;
        logic [PW-1:0]         div;
        slcd_pkg::slcd_phase_e phase;
        logic                  pol;
        slcd_pkg::slcd_phase_e out_phase;
        logic                  out_pol;
        logic                  run_d;
        logic                  rd_d;
        logic [1:0]            rd_src;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic [7:0]            com;
        logic [39:0]           seg;
        logic [19:0]           mask;
        logic [19:0]           port_rd;
        logic [19:0]           port_oe;
    } slcd_drv_s;

    slcd_drv_s st;
    slcd_drv_s next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] ph_idx(slcd_pkg::slcd_phase_e p);
        case (p)
            slcd_pkg::PH_COM0: ph_idx = 2'h0;
            slcd_pkg::PH_COM1: ph_idx = 2'h1;
            slcd_pkg::PH_COM2: ph_idx = 2'h2;
            slcd_pkg::PH_COM3: ph_idx = 2'h3;
            default:           ph_idx = 2'h0;
        endcase
    endfunction : ph_idx

    // common uses pol as is, segment the inverse; both select gives full
    function automatic logic [1:0] lvl(logic sel, logic p);
        if (p) begin
            lvl = sel ? slcd_pkg::LVL_GND : slcd_pkg::LVL_TWO;
        end else begin
            lvl = sel ? slcd_pkg::LVL_FULL : slcd_pkg::LVL_THIRD;
        end
    endfunction : lvl

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        dmem_hit;
    logic [4:0]  dmem_idx;
    logic [3:0]  mem_rdata;
    logic [19:0] plane;
    logic [2:0]  sel;
    logic [3:0]  pin_code;
    logic        run;
    logic        tick;
    logic [PW-1:0] div_mask;

    assign dmem_hit = i_addr >= slcd_pkg::DMEM_FIRST &&
                      i_addr <= slcd_pkg::DMEM_LAST;
    assign dmem_idx = 5'(i_addr - slcd_pkg::DMEM_FIRST);
    assign sel      = st.mode[slcd_pkg::SEL_LSB +: 3];
    assign pin_code = st.pinctl[slcd_pkg::PIN_LSB +: 4];

    slcd_mem #(
        .WORDS (NSEG),
        .DW    (4),
        .AW    (5)
    ) u_mem (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_we       (i_wr && dmem_hit),
        .i_waddr    (dmem_idx),
        .i_wdata    (i_wdata[3:0]),
        .i_raddr    (dmem_idx),
        .o_rdata    (mem_rdata),
        .i_bit      (ph_idx(st.phase)),
        .o_plane    (plane)
    );

    // ------------------------------------------------------------
    // scan clock
    // ------------------------------------------------------------
    // production parts ignore the gate register entirely
    assign run = EMULATION ? st.gate : 1'b1;
    // prohibited clock codes hold the scan rather than guess a rate
    assign div_mask = ({{(PW-1){1'b0}}, 1'b1} << (PW - int'(sel))) -
                      {{(PW-1){1'b0}}, 1'b1};
    assign tick = run && sel <= slcd_pkg::SEL_MAX &&
                  (st.div & div_mask) == div_mask;

    // ------------------------------------------------------------
    // per-pin drive
    // ------------------------------------------------------------
    logic [39:0] seg_next;
    logic [19:0] mask_next;

    generate
        for (genvar n = 0; n < NSEG; n++) begin : g_seg
            // byte at the top address feeds segment 0
            assign seg_next[2*n +: 2] = lvl(st.mode[slcd_pkg::EN_BIT] &&
                plane[NSEG-1-n], !st.out_pol);
            if (n < slcd_pkg::DED_SEG) begin : g_ded
                assign mask_next[n] = 1'b1;
            end else if (n == NSEG - 1) begin : g_last
                assign mask_next[n] = pin_code == slcd_pkg::PIN_ALL;
            end else begin : g_shr
                assign mask_next[n] = pin_code == slcd_pkg::PIN_ALL ||
                    (pin_code != 4'h0 && pin_code < slcd_pkg::PIN_ALL &&
                     n <= 4 + 2 * int'(pin_code));
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (i_wr && i_addr == slcd_pkg::MODE_ADDR) begin
            next_st.mode = {i_wdata[7:4], 4'h0};
        end
        if (i_wr && i_addr == slcd_pkg::PINCTL_ADDR) begin
            next_st.pinctl = {i_wdata[7:4], 3'h0, i_wdata[0]};
        end
        if (EMULATION && i_wr && i_addr == slcd_pkg::GATE_ADDR) begin
            next_st.gate = i_wdata[slcd_pkg::GATE_BIT];
        end
        // stopped clock clears the divider; the phase holds where it stands
        next_st.div = run ? st.div + 1'b1 : '0;
        if (tick) begin
            case (st.phase)
                slcd_pkg::PH_COM0: next_st.phase = slcd_pkg::PH_COM1;
                slcd_pkg::PH_COM1: next_st.phase = slcd_pkg::PH_COM2;
                slcd_pkg::PH_COM2: next_st.phase = slcd_pkg::PH_COM3;
                slcd_pkg::PH_COM3: begin
                    next_st.phase = slcd_pkg::PH_COM0;
                    next_st.pol   = !st.pol;
                end
                default: next_st.phase = slcd_pkg::PH_COM0;
            endcase
        end
        // plane lags phase by one cycle, so the output copy does too
        next_st.out_phase = st.phase;
        next_st.out_pol   = st.pol;
        next_st.run_d     = run;
        for (int c = 0; c < 4; c++) begin
            next_st.com[2*c +: 2] = st.run_d ?
                lvl(ph_idx(st.out_phase) == 2'(c), st.out_pol) :
                slcd_pkg::LVL_GND;
        end
        next_st.seg = st.run_d ? seg_next : '0;
        next_st.mask    = mask_next;
        // same mask as the pin mask register, so both flip on one edge
        next_st.port_rd = i_port_in & ~mask_next;
        next_st.port_oe = i_port_out_en & ~mask_next;
        // read answers two cycles after the request; gate is write-only
        next_st.rd_d = i_rd;
        if (dmem_hit) begin
            next_st.rd_src = 2'h1;
        end else if (i_addr == slcd_pkg::MODE_ADDR) begin
            next_st.rd_src = 2'h2;
        end else if (i_addr == slcd_pkg::PINCTL_ADDR) begin
            next_st.rd_src = 2'h3;
        end else begin
            next_st.rd_src = 2'h0;
        end
        next_st.rvalid = st.rd_d;
        case (st.rd_src)
            2'h1:    next_st.rdata = {4'h0, mem_rdata};
            2'h2:    next_st.rdata = st.mode;
            2'h3:    next_st.rdata = st.pinctl;
            default: next_st.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st        <= '0;
            st.mode   <= slcd_pkg::MODE_RST;
            st.pinctl <= slcd_pkg::PINCTL_RST;
            st.gate   <= slcd_pkg::GATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata               = st.rdata;
    assign o_rvalid              = st.rvalid;
    assign o_common_outputs      = st.com;
    assign o_segment_outputs     = st.seg;
    assign o_segment_pin_mask    = st.mask;
    assign o_port_read           = st.port_rd;
    assign o_port_out_en         = st.port_oe;
    assign o_drive_supply_select = st.pinctl[slcd_pkg::SUPPLY_BIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    logic [2:0] sel_cnt;
    always_comb begin
        sel_cnt = '0;
        for (int c = 0; c < 4; c++) begin
            // select is an extreme level in either polarity
            sel_cnt = sel_cnt + 3'(
                o_common_outputs[2*c +: 2] == slcd_pkg::LVL_GND ||
                o_common_outputs[2*c +: 2] == slcd_pkg::LVL_FULL);
        end
    end

    a_upper_zero: assert property ((i_rd && dmem_hit) |-> ##2
        (o_rvalid && o_rdata[7:4] == 4'h0))
        else $error("display byte upper bits not zero");
    a_frame_wrap: assert property ((tick && st.phase == slcd_pkg::PH_COM3)
        |=> (st.phase == slcd_pkg::PH_COM0 && st.pol != $past(st.pol)))
        else $error("frame wrap or polarity flip wrong");
    a_phase_hold: assert property ((!tick) |=> $stable(st.phase))
        else $error("phase moved without scan tick");
    a_one_common: assert property ($past(st.run_d) |-> sel_cnt == 3'h1)
        else $error("not exactly one common selected");
    a_off_nonsel: assert property ((st.run_d && !st.mode[slcd_pkg::EN_BIT])
        |=> o_segment_outputs == {20{lvl(1'b0, !$past(st.out_pol))}})
        else $error("disabled display drives select");
    a_seg_top: assert property ((st.run_d && st.mode[slcd_pkg::EN_BIT] &&
        plane[NSEG-1]) |=> o_segment_outputs[1:0] ==
        lvl(1'b1, !$past(st.out_pol)))
        else $error("segment 0 not fed from top byte");
    a_gate_stop: assert property ((EMULATION && !st.gate && !st.run_d)
        |=> (st.div == '0 && o_common_outputs == 8'h00))
        else $error("scan runs with gate closed");
    a_prod_run: assert property (!EMULATION |-> run)
        else $error("production scan stopped by gate");
    a_reset_gate: assert property ($past(i_srst) |-> !st.gate)
        else $error("gate not cleared by reset");
    a_port_zero: assert property ((o_segment_pin_mask &
        (o_port_read | o_port_out_en)) == 20'h00000)
        else $error("segment pin leaks port function");

    c_frame_wrap: cover property (tick && st.phase == slcd_pkg::PH_COM3);
    c_display_on: cover property (st.run_d && st.mode[slcd_pkg::EN_BIT]);
    c_all_pins: cover property (pin_code == slcd_pkg::PIN_ALL);
endmodule : slcd_drv

//--- rtl/slcd_mem.sv
/*
 * Display memory: one CPU write port, one CPU read port and a bit-plane
 * read port that gives one chosen bit of every word at once.
 * Assumes a single clock and a synchronous active-high reset.
 */
module slcd_mem #(
    parameter int WORDS = 20,
    parameter int DW    = 4,
    parameter int AW    = 5
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_srst,
    input  wire logic              i_we,
    input  wire logic [AW-1:0]     i_waddr,
    input  wire logic [DW-1:0]     i_wdata,
    input  wire logic [AW-1:0]     i_raddr,
    output logic      [DW-1:0]     o_rdata,
    input  wire logic [1:0]        i_bit,
    output logic      [WORDS-1:0]  o_plane
);
    generate
        if (WORDS > (1 << AW) || DW < 4) begin : g_bad
            $error("slcd_mem: address or data width too small");
        end
    endgenerate

    typedef struct packed {
        logic [WORDS-1:0][DW-1:0] ram;
        logic [DW-1:0]            rdata;
        logic [WORDS-1:0]         plane;
    } slcd_mem_s;

    slcd_mem_s st;
    slcd_mem_s next_st;

    always_comb begin
        next_st = st;
        if (i_we && int'(i_waddr) < WORDS) begin
            next_st.ram[i_waddr] = i_wdata;
        end
        next_st.rdata = (int'(i_raddr) < WORDS) ? st.ram[i_raddr] : '0;
        for (int w = 0; w < WORDS; w++) begin
            next_st.plane[w] = st.ram[w][i_bit];
        end
    end

    // ram contents are cleared too, so the panel starts blank
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_plane = st.plane;
endmodule : slcd_mem

//--- rtl/slcd_pkg.sv
/*
 * Constants, field positions and types of the four-way multiplexed
 * segment panel driver.
 * Assumes an 8-bit CPU data bus with 16-bit byte addresses.
 */
// How it works
// - display memory is twenty consecutive CPU byte addresses read by scan
// - display bytes unused by segments behave as plain read/write RAM
// - only low four bits stored; upper bits read zero, write zero
// - commons selected in order first to fourth, repeated forever
// - during common n each segment shows bit n: one select
// - segment n fed from the byte at top address minus n
// - commons and segments alternate polarity, no steady DC on pixels
// - full drive only when common and segment both select
// - fixed one-third bias: ground, third, two thirds, full levels
// - segments five to nineteen share pins with ports; others dedicated
// - emulation build: scan clock runs only while gate bit 1 set
// - production build: gate register writes have no effect
// - drive voltage source selectable between internal and external
// - display disabled: every segment drives non-select level, except ground while the gate is closed
// - three-bit field divides main clock by 2^17, 2^16, 2^15, 2^14
// - pin in segment use reads zero as port, ignores port output mode
package slcd_pkg;
    // ------------------------------------------------------------
    // addresses
    // ------------------------------------------------------------
    localparam logic [15:0] DMEM_FIRST   = 16'hFA59;
    localparam logic [15:0] DMEM_LAST    = 16'hFA6C;
    localparam logic [15:0] MODE_ADDR    = 16'hFFB0;
    localparam logic [15:0] PINCTL_ADDR  = 16'hFFB2;
    localparam logic [15:0] GATE_ADDR    = 16'hFF4A;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          DMEM_WORDS   = 20;
    localparam int          DED_SEG      = 5;
    localparam int          EN_BIT       = 7;
    localparam int          SEL_LSB      = 4;
    localparam int          PIN_LSB      = 4;
    localparam int          SUPPLY_BIT   = 0;
    localparam int          GATE_BIT     = 1;
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [7:0]  PINCTL_RST   = 8'h00;
    localparam logic        GATE_RST     = 1'b0;
    localparam logic [2:0]  SEL_MAX      = 3'h3;
    localparam logic [3:0]  PIN_ALL      = 4'h8;
    // slowest scan clock is the main clock over 2^17
    localparam int          PRESCALE_LOG2 = 17;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_GND   = 2'h0,
        LVL_THIRD = 2'h1,
        LVL_TWO   = 2'h2,
        LVL_FULL  = 2'h3
    } slcd_level_e;
    typedef enum logic [1:0] {
        PH_COM0 = 2'h0,
        PH_COM1 = 2'h1,
        PH_COM2 = 2'h3,
        PH_COM3 = 2'h2
    } slcd_phase_e;
endpackage : slcd_pkg

//--- verification/slcd_panel.sv
/*
 * Passive four-way multiplexed segment panel: works out which pixels
 * see the full drive swing.
 * Assumes level codes 0 to 3 on every common and segment line.
 */
module slcd_panel (
    input  wire logic [7:0]  i_common_outputs,
    input  wire logic [39:0] i_segment_outputs,
    output logic      [79:0] o_lit
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // pixels
    // ------------------------------------------------------------
    // only full swing lights; a third of the drive stays dark
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            for (int n = 0; n < 20; n++) begin
                o_lit[c*20+n] =
                    ({i_common_outputs[2*c+:2], i_segment_outputs[2*n+:2]}
                     == 4'hC) ||
                    ({i_common_outputs[2*c+:2], i_segment_outputs[2*n+:2]}
                     == 4'h3);
            end
        end
    end
endmodule : slcd_panel

//--- verification/testbench.sv
/*
 * Self-checking bench of the segment panel driver: register bus, pin
 * sharing and the panel scan seen through a passive panel.
 * Assumes the emulation build and a shortened scan prescaler.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PW    = 4;
    localparam int LIMIT = 6000;
    logic        i_core_clk    = 1'h0;
    logic        i_srst        = 1'h1;
    logic [15:0] i_addr        = 16'h0000;
    logic        i_wr          = 1'h0;
    logic        i_rd          = 1'h0;
    logic [7:0]  i_wdata       = 8'h00;
    logic [19:0] i_port_in     = 20'h00000;
    logic [19:0] i_port_out_en = 20'h00000;
    logic [7:0]  o_rdata, o_common_outputs;
    logic        o_rvalid, o_drive_supply_select, en;
    logic [39:0] o_segment_outputs;
    logic [19:0] o_segment_pin_mask, o_port_read, o_port_out_en;
    logic [79:0] lit;
    logic [3:0]  mem [20];
    logic [7:0]  d;
    int miscompares = 0, n_tests = 0, cyc = 0, sel, p, lp, nchg, dwell;
    logic        mon = 1'h0, pol, lpol;

    always #25 i_core_clk = ~i_core_clk;

    slcd_drv #(.EMULATION(1'b1), .PRESCALE_W(PW)) dut_u (
        .i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_common_outputs(o_common_outputs),
        .o_segment_outputs(o_segment_outputs),
        .o_segment_pin_mask(o_segment_pin_mask), .i_port_in(i_port_in),
        .i_port_out_en(i_port_out_en), .o_port_read(o_port_read),
        .o_port_out_en(o_port_out_en),
        .o_drive_supply_select(o_drive_supply_select));
    slcd_panel panel_u (.i_common_outputs(o_common_outputs),
        .i_segment_outputs(o_segment_outputs), .o_lit(lit));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [79:0] e, logic [79:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task automatic wr(logic [15:0] a, logic [7:0] v);
        @(posedge i_core_clk);
        i_wr <= 1'h1; i_addr <= a; i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 1'h0;
    endtask : wr
    // answer stands one cycle, from the edge after the strobe is taken
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'h1; i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'h0;
        @(posedge i_core_clk);
        #1;
        chk("rvalid", 1, o_rvalid);
        chk("rdata", e, o_rdata);
    endtask : rd
    function automatic logic [19:0] mask_exp(logic [3:0] code);
        logic [19:0] m;
        m = 20'h0001F;
        if (code == 4'h8) m = 20'hFFFFF;
        else if (code >= 4'h1 && code <= 4'h7)
            for (int n = 5; n < 5 + 2 * code; n++) m[n] = 1'h1;
        return m;
    endfunction : mask_exp
    // segment n takes the byte at the top address minus n
    function automatic logic [39:0] seg_exp(int ph, logic pl);
        logic [39:0] s;
        for (int n = 0; n < 20; n++)
            s[2*n+:2] = (en && mem[19-n][ph]) ? (pl ? 2'h3 : 2'h0)
                                              : (pl ? 2'h1 : 2'h2);
        return s;
    endfunction : seg_exp
    function automatic logic [79:0] lit_exp(int ph);
        logic [79:0] l;
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < 20; n++)
                l[c*20+n] = (c == ph) && en && mem[19-n][c];
        return l;
    endfunction : lit_exp
    function automatic logic [7:0] com_exp(int ph, logic pl);
        logic [7:0] v;
        for (int c = 0; c < 4; c++)
            v[2*c+:2] = (c == ph) ? (pl ? 2'h0 : 2'h3) : (pl ? 2'h2 : 2'h1);
        return v;
    endfunction : com_exp

    // ------------------------------------------------------------
    // scan monitor and time limit
    // ------------------------------------------------------------
    always @(negedge i_core_clk) begin
        if (mon) begin
            p = 0;
            pol = 1'h0;
            for (int c = 0; c < 4; c++) begin
                if (o_common_outputs[2*c+:2] == 2'h3) p = c;
                if (o_common_outputs[2*c+:2] == 2'h0) begin
                    p = c;
                    pol = 1'h1;
                end
            end
            chk("commons", com_exp(p, pol), o_common_outputs);
            chk("segments", seg_exp(p, pol), o_segment_outputs);
            chk("pixels", lit_exp(p), lit);
            if (nchg == 0 || p != lp || pol != lpol) begin
                if (nchg > 0) begin
                    chk("next_common", (lp + 1) % 4, p);
                    chk("polarity", lpol ^ (lp == 3), pol);
                end
                if (nchg > 1) chk("dwell", 1 << (PW - sel), dwell);
                nchg++;
                dwell = 0;
            end
            lp = p;
            lpol = pol;
            dwell++;
        end
    end
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(98022));
        repeat (12) @(posedge i_core_clk);
        i_srst <= 1'h0;
        rd(slcd_pkg::MODE_ADDR, 8'h00);
        rd(slcd_pkg::PINCTL_ADDR, 8'h00);
        rd(slcd_pkg::GATE_ADDR, 8'h00);
        rd(16'h1234, 8'h00);
        chk("commons_idle", 0, o_common_outputs);
        $display("test reset done");
        for (int i = 0; i < 20; i++) begin
            d = 8'($urandom);
            wr(slcd_pkg::DMEM_FIRST + 16'(i), {4'h0, d[3:0]});
            mem[i] = d[3:0];
        end
        for (int i = 0; i < 20; i++)
            rd(slcd_pkg::DMEM_FIRST + 16'(i), {4'h0, mem[i]});
        rd(slcd_pkg::DMEM_FIRST - 16'h0001, 8'h00);
        rd(slcd_pkg::DMEM_LAST + 16'h0001, 8'h00);
        $display("test display memory done");
        for (int k = 0; k < 17; k++) begin
            d = {4'(k == 0 ? 8 : k % 16), 3'h7, 1'($urandom)};
            @(posedge i_core_clk);
            i_port_in <= 20'($urandom);
            i_port_out_en <= 20'($urandom);
            wr(slcd_pkg::PINCTL_ADDR, d);
            rd(slcd_pkg::PINCTL_ADDR, d & 8'hF1);
            chk("pin_mask", mask_exp(d[7:4]), o_segment_pin_mask);
            chk("port_read", i_port_in & ~mask_exp(d[7:4]),
                o_port_read);
            chk("port_oe", i_port_out_en & ~mask_exp(d[7:4]),
                o_port_out_en);
            chk("supply", d[0], o_drive_supply_select);
        end
        $display("test pin sharing done");
        wr(slcd_pkg::MODE_ADDR, 8'h80);
        repeat (40) @(posedge i_core_clk);
        chk("gate_closed", 0, o_common_outputs);
        wr(slcd_pkg::GATE_ADDR, 8'h02);
        for (int s = 0; s < 4; s++) begin
            d = 8'($urandom);
            wr(slcd_pkg::DMEM_FIRST + 16'(s * 5), {4'h0, d[3:0]});
            mem[s*5] = d[3:0];
            sel = s;
            en = (s != 2);
            wr(slcd_pkg::MODE_ADDR, {en, 3'(s), 4'hF});
            rd(slcd_pkg::MODE_ADDR, {en, 3'(s), 4'h0});
            repeat (8) @(posedge i_core_clk);
            nchg = 0;
            mon = 1'h1;
            repeat (20 << (PW - s)) @(posedge i_core_clk);
            mon = 1'h0;
            $display("test scan pass %0d done", s);
        end
        // prohibited clock code must hold the scan where it stands
        wr(slcd_pkg::MODE_ADDR, 8'hC0);
        rd(slcd_pkg::MODE_ADDR, 8'hC0);
        d = o_common_outputs;
        repeat (40) @(posedge i_core_clk);
        #1;
        chk("frozen_com", d, o_common_outputs);
        wr(slcd_pkg::GATE_ADDR, 8'h00);
        repeat (6) @(posedge i_core_clk);
        chk("stopped_com", 0, o_common_outputs);
        chk("stopped_seg", 0, o_segment_outputs);
        rd(slcd_pkg::GATE_ADDR, 8'h00);
        $display("test gate done");
        print_verdict();
    end
endmodule : testbench
